// file: hdl/dmx_data_move_exchange_unit.sv
// Execution datapath for transfers, conditional transfers and exchanges
`timescale 1ns/1ps
`default_nettype none
module dmx_data_move_exchange_unit (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Request
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire dmx_pkg::dmx_req_type req_in,
  // Result
  output logic done_out,
  output logic fault_out,
  output logic dst_we_out,
  output logic [31:0] dst_data_out,
  output logic src_we_out,
  output logic [31:0] src_data_out,
  output logic acc_we_out,
  output logic [31:0] acc_data_out,
  output logic dhi_we_out,
  output logic [31:0] dhi_data_out,
  output logic flags_we_out,
  output dmx_pkg::dmx_flags_type flags_out,
  // Memory and bus lock
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic mem_wide_out,
  output logic [31:0] mem_addr_out,
  output logic [63:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [63:0] mem_rdata_in,
  output logic bus_lock_out
);
  typedef enum {ST_IDLE, ST_READ, ST_EXEC, ST_WRITE, ST_DONE} dmx_state_type;

  logic [dmx_pkg::DMX_SYNC_STAGES-1:0] rst_sync_ff;
  logic rst_n;
  dmx_state_type state_ff;
  dmx_state_type nxt_state;
  dmx_pkg::dmx_req_type req_ff;
  dmx_pkg::dmx_res_type res_ff;
  dmx_pkg::dmx_res_type nxt_res;
  logic [63:0] rdata_ff;
  logic lock_ff;
  logic nxt_lock;

  // One code per synonym pair, so aliases decode alike
  function automatic logic cond_true(input logic [3:0] cc, input dmx_pkg::dmx_flags_type f);
    logic r;
    r = 1'b0;
    case (cc)
      dmx_pkg::DMX_CC_OVF: r = f.overflow_flag;
      dmx_pkg::DMX_CC_NOVF: r = ~f.overflow_flag;
      dmx_pkg::DMX_CC_BELOW: r = f.carry_flag;
      dmx_pkg::DMX_CC_AE: r = ~f.carry_flag;
      dmx_pkg::DMX_CC_EQ: r = f.zero_flag;
      dmx_pkg::DMX_CC_NE: r = ~f.zero_flag;
      dmx_pkg::DMX_CC_BE: r = f.carry_flag | f.zero_flag;
      dmx_pkg::DMX_CC_ABOVE: r = ~(f.carry_flag | f.zero_flag);
      dmx_pkg::DMX_CC_SIGN: r = f.sign_flag;
      dmx_pkg::DMX_CC_NSIGN: r = ~f.sign_flag;
      dmx_pkg::DMX_CC_PAR: r = f.parity_flag;
      dmx_pkg::DMX_CC_NPAR: r = ~f.parity_flag;
      dmx_pkg::DMX_CC_LESS: r = f.sign_flag ^ f.overflow_flag;
      dmx_pkg::DMX_CC_GE: r = ~(f.sign_flag ^ f.overflow_flag);
      dmx_pkg::DMX_CC_LE: r = (f.sign_flag ^ f.overflow_flag) | f.zero_flag;
      default: r = ~((f.sign_flag ^ f.overflow_flag) | f.zero_flag);
    endcase
    return r;
  endfunction : cond_true

  // Flags of a+b or a-b at 16 or 32 bits
  function automatic dmx_pkg::dmx_flags_type arith_flags(input logic [31:0] a,
      input logic [31:0] b, input logic sub, input logic wide);
    logic [31:0] bb;
    logic [32:0] s;
    logic carry;
    logic as;
    logic bs;
    logic rs;
    dmx_pkg::dmx_flags_type f;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {32'h00000000, sub};
    as = wide ? a[31] : a[15];
    bs = wide ? bb[31] : bb[15];
    rs = wide ? s[31] : s[15];
    carry = wide ? s[32] : (a[16] ^ bb[16] ^ s[16]);
    f.carry_flag = carry ^ sub;
    f.aux_flag = a[4] ^ bb[4] ^ s[4] ^ sub;
    f.parity_flag = ~^s[7:0];
    f.zero_flag = wide ? (s[31:0] == 32'h00000000) : (s[15:0] == 16'h0000);
    f.sign_flag = rs;
    f.overflow_flag = (as == bs) && (rs != as);
    return f;
  endfunction : arith_flags

  function automatic logic [31:0] byte_rev(input logic [31:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < dmx_pkg::DMX_BYTES; i++)
    begin
      r[8*i +: 8] = a[8*(dmx_pkg::DMX_BYTES-1-i) +: 8];
    end
    return r;
  endfunction : byte_rev

  function automatic logic is_kind(input dmx_pkg::dmx_kind_type k,
      input dmx_pkg::dmx_kind_type want);
    return k == want;
  endfunction : is_kind

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_ff <= '0;
    else
      rst_sync_ff <= {rst_sync_ff[dmx_pkg::DMX_SYNC_STAGES-2:0], 1'b1};
  end
  assign rst_n = rst_sync_ff[dmx_pkg::DMX_SYNC_STAGES-1];

  // Decoded request
  wire dmx_pkg::dmx_kind_type sk = req_ff.src_kind;
  wire dmx_pkg::dmx_kind_type dk = req_ff.dst_kind;
  wire s_gpr = is_kind(sk, dmx_pkg::DMX_K_GPR);
  wire s_mem = is_kind(sk, dmx_pkg::DMX_K_MEM);
  wire s_seg = is_kind(sk, dmx_pkg::DMX_K_SEG);
  wire s_imm = is_kind(sk, dmx_pkg::DMX_K_IMM);
  wire s_sys = is_kind(sk, dmx_pkg::DMX_K_CTL) | is_kind(sk, dmx_pkg::DMX_K_DBG);
  wire d_gpr = is_kind(dk, dmx_pkg::DMX_K_GPR);
  wire d_mem = is_kind(dk, dmx_pkg::DMX_K_MEM);
  wire d_seg = is_kind(dk, dmx_pkg::DMX_K_SEG);
  wire d_sys = is_kind(dk, dmx_pkg::DMX_K_CTL) | is_kind(dk, dmx_pkg::DMX_K_DBG);
  wire dmx_pkg::dmx_op_type op = req_ff.op;
  wire is_wide_cas = (op == dmx_pkg::DMX_OP_CAS_WIDE);
  wire any_mem = s_mem | d_mem;
  // Seg-seg and mem-mem fall out of the allowed set below
  wire xfer_ok = (s_mem & (d_gpr | d_seg)) | ((s_gpr | s_seg) & d_mem) |
    (s_gpr & (d_gpr | d_seg | d_sys)) | ((s_seg | s_sys) & d_gpr) |
    (s_imm & (d_gpr | d_mem));
  wire cond_ok = d_gpr & (s_gpr | s_mem);
  wire swap_ok = (s_gpr & (d_gpr | d_mem)) | (s_mem & d_gpr);
  wire rmw_ok = s_gpr & (d_gpr | d_mem);
  logic legal;
  always_comb
  begin
    case (op)
      dmx_pkg::DMX_OP_TRANSFER: legal = xfer_ok;
      dmx_pkg::DMX_OP_COND: legal = cond_ok;
      dmx_pkg::DMX_OP_SWAP: legal = swap_ok;
      dmx_pkg::DMX_OP_BREV: legal = d_gpr & req_ff.wide;
      dmx_pkg::DMX_OP_SUM: legal = rmw_ok;
      dmx_pkg::DMX_OP_CAS: legal = rmw_ok;
      dmx_pkg::DMX_OP_CAS_WIDE: legal = d_mem;
      default: legal = 1'b0;
    endcase
  end
  // Plain transfer to memory needs no read of the old value
  wire need_read = legal & (is_wide_cas | (any_mem & ~(op == dmx_pkg::DMX_OP_TRANSFER & d_mem)));
  wire atomic_op = (op == dmx_pkg::DMX_OP_SUM) | (op == dmx_pkg::DMX_OP_CAS) | is_wide_cas;
  wire need_lock = need_read & (((op == dmx_pkg::DMX_OP_SWAP) & any_mem) |
    (req_ff.locked & atomic_op));

  // Operand values
  wire [31:0] mask = req_ff.wide ? dmx_pkg::DMX_MASK32 : dmx_pkg::DMX_MASK16;
  wire [31:0] opa = (d_mem ? rdata_ff[31:0] : req_ff.dst_val) & mask;
  wire [31:0] opb = (s_mem ? rdata_ff[31:0] : req_ff.src_val) & mask;
  wire [31:0] sum = (opa + opb) & mask;
  wire [31:0] accm = req_ff.acc & mask;
  wire cas_eq = (accm == opa);
  wire [63:0] pair_cmp = {req_ff.dhi, req_ff.acc};
  wire [63:0] pair_new = {req_ff.cnt, req_ff.base};
  wire wide_eq = (pair_cmp == rdata_ff);
  wire take = cond_true(req_ff.cc, req_ff.flags);

  // Result of the operation, written on its destination kind
  always_comb
  begin
    nxt_res = '0;
    nxt_res.flags = req_ff.flags;
    if (!legal)
      nxt_res.fault = 1'b1;
    else
    begin
      case (op)
        dmx_pkg::DMX_OP_TRANSFER:
        begin
          nxt_res.dst = opb;
          nxt_res.dst_we = ~d_mem;
          nxt_res.mem_wr = d_mem;
        end
        dmx_pkg::DMX_OP_COND:
        begin
          nxt_res.dst = opb;
          nxt_res.dst_we = take;
        end
        dmx_pkg::DMX_OP_SWAP:
        begin
          nxt_res.dst = opb;
          nxt_res.src = opa;
          nxt_res.dst_we = ~d_mem;
          nxt_res.src_we = ~s_mem;
          nxt_res.mem_wr = any_mem;
        end
        dmx_pkg::DMX_OP_BREV:
        begin
          nxt_res.dst = byte_rev(opa);
          nxt_res.dst_we = 1'b1;
        end
        dmx_pkg::DMX_OP_SUM:
        begin
          nxt_res.src = opa;
          nxt_res.src_we = 1'b1;
          nxt_res.dst = sum;
          nxt_res.dst_we = ~d_mem;
          nxt_res.mem_wr = d_mem;
          nxt_res.flags = arith_flags(opa, opb, 1'b0, req_ff.wide);
          nxt_res.flags_we = 1'b1;
        end
        dmx_pkg::DMX_OP_CAS:
        begin
          nxt_res.dst = opb;
          nxt_res.dst_we = cas_eq & ~d_mem;
          nxt_res.mem_wr = cas_eq & d_mem;
          nxt_res.acc = opa;
          nxt_res.acc_we = ~cas_eq;
          nxt_res.flags = arith_flags(accm, opa, 1'b1, req_ff.wide);
          nxt_res.flags_we = 1'b1;
        end
        default:
        begin
          nxt_res.mem_wr = wide_eq;
          nxt_res.acc = rdata_ff[31:0];
          nxt_res.dhi = rdata_ff[63:32];
          nxt_res.acc_we = ~wide_eq;
          nxt_res.dhi_we = ~wide_eq;
          nxt_res.flags.zero_flag = wide_eq;
          nxt_res.flags_we = 1'b1;
        end
      endcase
      nxt_res.mem_wdata = is_wide_cas ? pair_new :
        {32'h00000000, (op == dmx_pkg::DMX_OP_SWAP) ? (s_mem ? opa : opb) : nxt_res.dst};
    end
  end

  // Sequencer; the lock spans read through write of one operation
  always_comb
  begin
    nxt_state = state_ff;
    nxt_lock = lock_ff;
    case (state_ff)
      ST_IDLE: if (req_valid_in) nxt_state = ST_READ;
      ST_READ:
      begin
        nxt_lock = need_lock;
        if (!need_read || mem_ack_in) nxt_state = ST_EXEC;
      end
      ST_EXEC: nxt_state = nxt_res.mem_wr ? ST_WRITE : ST_DONE;
      ST_WRITE: if (mem_ack_in) nxt_state = ST_DONE;
      ST_DONE:
      begin
        nxt_state = ST_IDLE;
        nxt_lock = 1'b0;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  wire go_read = req_ready_out & req_valid_in;
  wire take_rdata = (state_ff == ST_READ) & need_read & mem_ack_in;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      lock_ff <= 1'b0;
      req_ff <= '0;
      res_ff <= '0;
      rdata_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      lock_ff <= nxt_lock;
      if (go_read)
        req_ff <= req_in;
      if (take_rdata)
        rdata_ff <= mem_rdata_in;
      if (state_ff == ST_EXEC)
        res_ff <= nxt_res;
    end
  end

  // Not ready while the internal reset copy is still low
  assign req_ready_out = rst_n & (state_ff == ST_IDLE);
  assign mem_rd_out = (state_ff == ST_READ) & need_read;
  assign mem_wr_out = (state_ff == ST_WRITE);
  assign mem_wide_out = is_wide_cas;
  assign mem_addr_out = req_ff.addr;
  assign mem_wdata_out = res_ff.mem_wdata;
  assign bus_lock_out = lock_ff | ((state_ff == ST_READ) & need_lock);
  wire fin = (state_ff == ST_DONE);
  assign done_out = fin;
  assign fault_out = fin & res_ff.fault;
  assign dst_we_out = fin & res_ff.dst_we;
  assign src_we_out = fin & res_ff.src_we;
  assign acc_we_out = fin & res_ff.acc_we;
  assign dhi_we_out = fin & res_ff.dhi_we;
  assign flags_we_out = fin & res_ff.flags_we;
  assign dst_data_out = res_ff.dst;
  assign src_data_out = res_ff.src;
  assign acc_data_out = res_ff.acc;
  assign dhi_data_out = res_ff.dhi;
  assign flags_out = res_ff.flags;
endmodule : dmx_data_move_exchange_unit
`default_nettype wire

// file: hdl/dmx_pkg.sv
// Shared types and constants for the data move and exchange unit
package dmx_pkg;
  localparam int DMX_W = 32;
  localparam int DMX_BYTES = 4;
  localparam int DMX_HALF = 16;
  localparam logic [31:0] DMX_MASK32 = 32'hFFFFFFFF;
  localparam logic [31:0] DMX_MASK16 = 32'h0000FFFF;
  localparam int DMX_SYNC_STAGES = 2;

  // Condition encodings; each synonym pair shares one code
  localparam logic [3:0] DMX_CC_OVF = 4'h0;
  localparam logic [3:0] DMX_CC_NOVF = 4'h1;
  localparam logic [3:0] DMX_CC_BELOW = 4'h2;
  localparam logic [3:0] DMX_CC_AE = 4'h3;
  localparam logic [3:0] DMX_CC_EQ = 4'h4;
  localparam logic [3:0] DMX_CC_NE = 4'h5;
  localparam logic [3:0] DMX_CC_BE = 4'h6;
  localparam logic [3:0] DMX_CC_ABOVE = 4'h7;
  localparam logic [3:0] DMX_CC_SIGN = 4'h8;
  localparam logic [3:0] DMX_CC_NSIGN = 4'h9;
  localparam logic [3:0] DMX_CC_PAR = 4'hA;
  localparam logic [3:0] DMX_CC_NPAR = 4'hB;
  localparam logic [3:0] DMX_CC_LESS = 4'hC;
  localparam logic [3:0] DMX_CC_GE = 4'hD;
  localparam logic [3:0] DMX_CC_LE = 4'hE;
  localparam logic [3:0] DMX_CC_GREATER = 4'hF;

  typedef enum logic [2:0] {
    DMX_OP_TRANSFER = 3'h0,
    DMX_OP_COND = 3'h1,
    DMX_OP_SWAP = 3'h2,
    DMX_OP_BREV = 3'h3,
    DMX_OP_SUM = 3'h4,
    DMX_OP_CAS = 3'h5,
    DMX_OP_CAS_WIDE = 3'h6
  } dmx_op_type;

  typedef enum logic [2:0] {
    DMX_K_GPR = 3'h0,
    DMX_K_SEG = 3'h1,
    DMX_K_MEM = 3'h2,
    DMX_K_IMM = 3'h3,
    DMX_K_CTL = 3'h4,
    DMX_K_DBG = 3'h5
  } dmx_kind_type;

  typedef struct packed {
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic aux_flag;
    logic parity_flag;
    logic carry_flag;
  } dmx_flags_type;

  typedef struct packed {
    dmx_op_type op;
    logic [3:0] cc;
    dmx_kind_type src_kind;
    dmx_kind_type dst_kind;
    logic wide;
    logic locked;
    logic [31:0] src_val;
    logic [31:0] dst_val;
    logic [31:0] acc;
    logic [31:0] dhi;
    logic [31:0] cnt;
    logic [31:0] base;
    logic [31:0] addr;
    dmx_flags_type flags;
  } dmx_req_type;

  typedef struct packed {
    logic fault;
    logic dst_we;
    logic src_we;
    logic acc_we;
    logic dhi_we;
    logic flags_we;
    logic mem_wr;
    logic [31:0] dst;
    logic [31:0] src;
    logic [31:0] acc;
    logic [31:0] dhi;
    logic [63:0] mem_wdata;
    dmx_flags_type flags;
  } dmx_res_type;
endpackage : dmx_pkg

// file: bench/dmx_unit_props.sv
// Port-level assertions for the data move and exchange unit
`timescale 1ns/1ps
`default_nettype none
module dmx_unit_props (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Request and result
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire dmx_pkg::dmx_req_type req_in,
  input wire logic done_out,
  input wire logic fault_out,
  input wire logic dst_we_out,
  input wire logic [31:0] dst_data_out,
  input wire logic src_we_out,
  input wire logic acc_we_out,
  input wire logic flags_we_out,
  // Memory and lock
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic mem_wide_out,
  input wire logic mem_ack_in,
  input wire logic bus_lock_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  dmx_pkg::dmx_req_type cap_ff;
  logic take;
  logic any_we;
  logic cond_op;
  assign take = req_valid_in & req_ready_out;
  assign any_we = dst_we_out | src_we_out | acc_we_out | flags_we_out;
  assign cond_op = take && req_in.op == dmx_pkg::DMX_OP_COND && req_in.src_kind == dmx_pkg::DMX_K_GPR;
  always_ff @(posedge clk_in)
  begin
    if (take)
      cap_ff <= req_in;
  end
  a_fault_no_write:
  assert property (fault_out |-> done_out && !any_we && !mem_wr_out)
    else $error("write during fault");
  a_we_at_done:
  assert property (any_we |-> done_out)
    else $error("write enable outside done");
  a_brev_bytes:
  assert property (take && req_in.op == dmx_pkg::DMX_OP_BREV && req_in.wide
    && req_in.dst_kind == dmx_pkg::DMX_K_GPR |-> ##3 done_out && dst_we_out
    && dst_data_out == {cap_ff.dst_val[7:0], cap_ff.dst_val[15:8], cap_ff.dst_val[23:16],
    cap_ff.dst_val[31:24]}) else $error("byte reversal wrong");
  a_eq_false_keep:
  assert property (cond_op && req_in.cc == dmx_pkg::DMX_CC_EQ && !req_in.flags.zero_flag
    |-> ##3 done_out && !dst_we_out) else $error("false condition wrote");
  a_below_true:
  assert property (cond_op && req_in.cc == dmx_pkg::DMX_CC_BELOW && req_in.flags.carry_flag
    |-> ##3 done_out && dst_we_out && dst_data_out == (cap_ff.src_val
    & (cap_ff.wide ? dmx_pkg::DMX_MASK32 : dmx_pkg::DMX_MASK16))) else $error("below move");
  a_swap_lock:
  assert property (take && req_in.op == dmx_pkg::DMX_OP_SWAP && ((req_in.src_kind ==
    dmx_pkg::DMX_K_MEM && req_in.dst_kind == dmx_pkg::DMX_K_GPR) || (req_in.src_kind ==
    dmx_pkg::DMX_K_GPR && req_in.dst_kind == dmx_pkg::DMX_K_MEM))
    |=> mem_rd_out && bus_lock_out) else $error("swap read not locked");
  a_lock_kept:
  assert property (bus_lock_out && mem_rd_out && mem_ack_in |=> bus_lock_out)
    else $error("lock dropped after read");
  a_wide_read:
  assert property (take && req_in.op == dmx_pkg::DMX_OP_CAS_WIDE && req_in.dst_kind ==
    dmx_pkg::DMX_K_MEM |=> mem_rd_out && mem_wide_out) else $error("wide read missing");
  a_wide_fault:
  assert property (take && req_in.op == dmx_pkg::DMX_OP_CAS_WIDE && req_in.dst_kind !=
    dmx_pkg::DMX_K_MEM |-> ##3 done_out && fault_out) else $error("wide to register taken");
  c_cas_wide: cover property (take && req_in.op == dmx_pkg::DMX_OP_CAS_WIDE);
  c_locked_write: cover property (bus_lock_out && mem_wr_out && mem_ack_in);
  c_fault: cover property (done_out && fault_out);
endmodule : dmx_unit_props
bind dmx_data_move_exchange_unit dmx_unit_props dmx_unit_props_inst (.clk_in, .resetn_in,
  .req_valid_in, .req_ready_out, .req_in, .done_out, .fault_out, .dst_we_out, .dst_data_out,
  .src_we_out, .acc_we_out, .flags_we_out, .mem_rd_out, .mem_wr_out, .mem_wide_out,
  .mem_ack_in, .bus_lock_out);
`default_nettype wire

// file: bench/dmx_mem_model.sv
// Single-word memory with adjustable acknowledge delay
`timescale 1ns/1ps
`default_nettype none
module dmx_mem_model (
  // Clock and bench control
  input wire logic clk_in,
  input wire logic [3:0] slow_in,
  input wire logic load_in,
  input wire logic [63:0] load_data_in,
  // Memory side of the unit
  input wire logic mem_rd_in,
  input wire logic mem_wr_in,
  input wire logic mem_wide_in,
  input wire logic [63:0] mem_wdata_in,
  output logic mem_ack_out,
  output logic [63:0] mem_rdata_out,
  output logic [63:0] word_out
);
  logic [3:0] wait_ff = 4'h0;
  logic ack_ff = 1'b0;
  assign mem_ack_out = ack_ff;
  // Not driven outside the ack cycle, so show the inverse
  assign mem_rdata_out = ack_ff ? word_out : ~word_out;
  // Sole bus master here, so nothing intervenes between read and write
  always @(posedge clk_in)
  begin
    ack_ff <= 1'b0;
    if (load_in)
      word_out <= load_data_in;
    else if ((mem_rd_in | mem_wr_in) & ~ack_ff)
    begin
      wait_ff <= wait_ff + 4'h1;
      if (wait_ff >= slow_in)
      begin
        wait_ff <= 4'h0;
        ack_ff <= 1'b1;
        if (mem_wr_in)
          word_out <= mem_wide_in ? mem_wdata_in : {word_out[63:32], mem_wdata_in[31:0]};
      end
    end
  end
endmodule : dmx_mem_model
`default_nettype wire

// file: bench/test_data_move_exchange_unit.sv
// Self-checking bench for the data move and exchange unit
`timescale 1ns/1ps
`default_nettype none
module test_data_move_exchange_unit;
  logic clk_in, resetn_in, req_valid_in, req_ready_out, done_out, fault_out, dst_we_out;
  logic src_we_out, acc_we_out, dhi_we_out, flags_we_out, mem_rd_out, mem_wr_out;
  logic mem_wide_out, mem_ack_in, bus_lock_out, load, saw_lock, saw_wr;
  logic [31:0] dst_data_out, src_data_out, acc_data_out, dhi_data_out, mem_addr_out;
  logic [63:0] mem_wdata_out, mem_rdata_in, load_data, word;
  logic [3:0] slow;
  dmx_pkg::dmx_req_type req_in, r;
  dmx_pkg::dmx_flags_type flags_out;
  int err_count, checked;

  dmx_data_move_exchange_unit dmx_data_move_exchange_unit_inst (.clk_in, .resetn_in,
    .req_valid_in, .req_ready_out, .req_in, .done_out, .fault_out, .dst_we_out, .dst_data_out,
    .src_we_out, .src_data_out, .acc_we_out, .acc_data_out, .dhi_we_out, .dhi_data_out,
    .flags_we_out, .flags_out, .mem_rd_out, .mem_wr_out, .mem_wide_out, .mem_addr_out,
    .mem_wdata_out, .mem_ack_in, .mem_rdata_in, .bus_lock_out);
  dmx_mem_model dmx_mem_model_inst (.clk_in, .slow_in(slow), .load_in(load),
    .load_data_in(load_data), .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
    .mem_wide_in(mem_wide_out), .mem_wdata_in(mem_wdata_out), .mem_ack_out(mem_ack_in),
    .mem_rdata_out(mem_rdata_in), .word_out(word));

  task automatic chk(input logic c, input string m);
    checked++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic mk(input logic [2:0] op, input logic [2:0] sk, input logic [2:0] dk);
    r = '0;
    r.op = dmx_pkg::dmx_op_type'(op);
    r.src_kind = dmx_pkg::dmx_kind_type'(sk);
    r.dst_kind = dmx_pkg::dmx_kind_type'(dk);
    r.wide = 1'b1;
  endtask : mk

  // Preload memory, then hold the request until the taking edge
  task automatic go(input logic [63:0] m);
    int n;
    n = 0;
    @(posedge clk_in);
    load <= 1'b1;
    load_data <= m;
    @(posedge clk_in);
    load <= 1'b0;
    req_in <= r;
    req_valid_in <= 1'b1;
    saw_lock = 1'b0;
    saw_wr = 1'b0;
    do @(negedge clk_in); while (req_ready_out !== 1'b1 && ++n < 50);
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    do @(negedge clk_in); while (done_out !== 1'b1 && ++n < 200);
    chk(n < 200, "no completion");
  endtask : go

  task automatic t_xfer();
    logic [5:0] p [15] = '{6'h00, 6'h10, 6'h11, 6'h02, 6'h0A, 6'h01, 6'h08, 6'h04, 6'h20,
      6'h05, 6'h28, 6'h18, 6'h1A, 6'h12, 6'h09};
    logic bad;
    for (int i = 0; i < 15; i++)
    begin
      bad = i > 12;
      mk(3'h0, p[i][5:3], p[i][2:0]);
      r.src_val = 32'h600D0000 | 32'(i);
      go(64'h0123456789ABCDEF);
      chk(fault_out === bad, "transfer fault");
      if (p[i][2:0] == 3'h2)
        chk(word[31:0] === (bad ? 32'h89ABCDEF : r.src_val), "transfer store");
      else
        chk(dst_we_out === !bad && (bad || dst_data_out === (p[i][5:3] == 3'h2 ?
          32'h89ABCDEF : r.src_val)), "transfer data");
    end
  endtask : t_xfer

  task automatic t_cond(input dmx_pkg::dmx_flags_type f, input logic [2:0] sk,
      input logic [63:0] m);
    logic sx, sz, cz;
    logic [15:0] e;
    logic [31:0] v;
    sx = f.sign_flag ^ f.overflow_flag;
    sz = sx | f.zero_flag;
    cz = f.carry_flag | f.zero_flag;
    e = {~sz, sz, ~sx, sx, ~f.parity_flag, f.parity_flag, ~f.sign_flag, f.sign_flag, ~cz, cz,
      ~f.zero_flag, f.zero_flag, ~f.carry_flag, f.carry_flag, ~f.overflow_flag, f.overflow_flag};
    v = sk == 3'h2 ? m[31:0] : 32'h5A5AC3C3;
    for (int i = 0; i < 16; i++)
    begin
      mk(3'h1, sk, 3'h0);
      r.cc = 4'(i);
      r.flags = f;
      r.wide = i[0];
      r.src_val = 32'h5A5AC3C3;
      r.dst_val = 32'h11111111;
      go(m);
      chk(dst_we_out === e[i], "condition");
      if (e[i])
        chk(dst_data_out === (i[0] ? v : v & 32'h0000FFFF), "moved value");
    end
  endtask : t_cond

  task automatic t_exch();
    mk(3'h2, 3'h0, 3'h0);
    r.src_val = 32'hAAAA5555;
    r.dst_val = 32'h12345678;
    go('0);
    chk(dst_we_out && src_we_out && dst_data_out === 32'hAAAA5555
      && src_data_out === 32'h12345678, "swap registers");
    mk(3'h2, 3'h0, 3'h2);
    r.src_val = 32'h0BADF00D;
    r.addr = 32'h0000A5A0;
    slow = 4'h3;
    go(64'h00000000CAFEBABE);
    slow = 4'h0;
    chk(saw_lock && mem_addr_out === 32'h0000A5A0 && src_data_out === 32'hCAFEBABE
      && word[31:0] === 32'h0BADF00D, "swap memory");
    mk(3'h3, 3'h0, 3'h0);
    r.dst_val = 32'h11223344;
    go('0);
    chk(dst_data_out === 32'h44332211, "reverse once");
    r.dst_val = dst_data_out;
    go('0);
    chk(dst_data_out === 32'h11223344, "reverse twice");
  endtask : t_exch

  task automatic t_arith();
    mk(3'h4, 3'h0, 3'h0);
    r.dst_val = 32'h00000001;
    r.src_val = 32'hFFFFFFFF;
    go('0);
    chk(dst_data_out === 32'h0 && src_data_out === 32'h1 && flags_we_out
      && flags_out.zero_flag && flags_out.carry_flag, "sum registers");
    r.wide = 1'b0;
    r.dst_val = 32'h1234FFFF;
    r.src_val = 32'h00000001;
    go('0);
    chk(dst_data_out === 32'h0 && src_data_out === 32'h0000FFFF && flags_out.zero_flag
      && flags_out.carry_flag, "sum half width");
    mk(3'h4, 3'h0, 3'h2);
    r.locked = 1'b1;
    r.src_val = 32'h00000005;
    go(64'h0000000000000010);
    chk(saw_lock && word[31:0] === 32'h15 && src_data_out === 32'h10, "sum locked");
    mk(3'h5, 3'h0, 3'h0);
    r.acc = 32'h7;
    r.dst_val = 32'h7;
    r.src_val = 32'h9;
    go('0);
    chk(dst_we_out && dst_data_out === 32'h9 && flags_out.zero_flag, "cas equal");
    r.acc = 32'h5;
    go('0);
    chk(acc_we_out && !dst_we_out && acc_data_out === 32'h7 && flags_out === 6'h15,
      "cas unequal");
    mk(3'h5, 3'h0, 3'h2);
    r.locked = 1'b1;
    r.acc = 32'h33;
    r.src_val = 32'h44;
    go(64'h0000000000000033);
    chk(saw_lock && word[31:0] === 32'h44, "cas locked");
  endtask : t_arith

  task automatic t_wide();
    mk(3'h6, 3'h0, 3'h2);
    r.locked = 1'b1;
    r.dhi = 32'hDEAD0001;
    r.acc = 32'hBEEF0002;
    r.cnt = 32'h0C0C0C0C;
    r.base = 32'h0B0B0B0B;
    go(64'hDEAD0001BEEF0002);
    chk(saw_lock && word === 64'h0C0C0C0C0B0B0B0B && flags_out.zero_flag,
      "wide equal");
    r.acc = 32'hBEEF0003;
    go(64'hDEAD0001BEEF0002);
    chk(!saw_wr && acc_we_out && dhi_we_out && acc_data_out === 32'hBEEF0002
      && dhi_data_out === 32'hDEAD0001 && !flags_out.zero_flag, "wide unequal");
    r.dst_kind = dmx_pkg::DMX_K_GPR;
    go('0);
    chk(fault_out === 1'b1, "wide to register");
  endtask : t_wide

  task automatic finish_test();
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  always @(negedge clk_in)
  begin
    saw_lock |= bus_lock_out;
    saw_wr |= mem_wr_out;
  end

  initial
  begin
    #20000;
    err_count++;
    finish_test();
  end

  initial
  begin
    resetn_in = 1'b0;
    req_valid_in = 1'b0;
    req_in = '0;
    r = '0;
    load = 1'b0;
    load_data = '0;
    slow = 4'h0;
    saw_lock = 1'b0;
    saw_wr = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_xfer();
    t_cond(6'h23, 3'h0, '0);
    slow = 4'h2;
    t_cond(6'h18, 3'h2, 64'hFFFF0000A5A5F00F);
    slow = 4'h0;
    t_exch();
    t_arith();
    t_wide();
    finish_test();
  end
endmodule : test_data_move_exchange_unit
`default_nettype wire
